// *** bench/tb.sv ***
// Purpose: self-checking bench of the user watchdog
// Assumes: user pin clock selected, then the internal oscillator; setting 0
// Notes: setting 0 gives a count of eight ticks
`timescale 1ns/10ps
module tb;
    import wdt_pkg::*;
    logic pclk = 1'b0;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata, r;
    logic pready, pslverr, irq, reconfig_factory, e, pin, rst_n, done;
    logic [mode_w-1:0] image_mode;
    int n_mismatch = 0;
    int n_compared = 0;
    int n_reconf = 0;
    localparam logic [31:0] en = 32'h2000_0000;
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        if (reconfig_factory === 1'b1) n_reconf <= n_reconf + 1;
    end
    remote_upgrade_user_watchdog u_remote_upgrade_user_watchdog (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .user_supplied_clock_pin(pin), .watchdog_restart_n(rst_n), .app_load_done(done),
        .irq, .reconfig_factory, .image_mode);
    wdt_user_logic u_wdt_user_logic (.pclk, .user_supplied_clock_pin(pin),
        .watchdog_restart_n(rst_n), .app_load_done(done));
    task close_out();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // only the watchdog ends a wait for an answer that never comes
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask : rd
    // irq is registered from the next status, in the same cycle as status, so let it settle
    task irq_is(input logic exp);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask : irq_is
    initial begin
        #200000;
        n_mismatch++;
        close_out();
    end
    initial begin
        presetn <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(off_ctrl, 32'h0000_0fff);
        rd(off_count, {3'h0, set_rst, low_fill});
        rd(off_mode, 32'h0);
        rd(8'h18, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, off_ctrl, 32'h0000_1000);
        rd(off_count, 32'h8);
        apb(1'b1, off_mode, 32'h1);
        rd(off_mode, 32'h1);
        apb(1'b0, off_stat, 32'h0);
        chk({31'h0, r[29]}, 32'h0);
        u_wdt_user_logic.load();
        rd(off_mode, 32'h2);
        chk({30'h0, image_mode}, 32'h2);
        rd(off_stat, en | 32'h8);
        apb(1'b1, off_ctrl, 32'h0000_1fff);
        rd(off_count, 32'h8);
        u_wdt_user_logic.edges(3);
        rd(off_stat, en | 32'h5);
        u_wdt_user_logic.restart(10);
        rd(off_stat, en | 32'h5);
        u_wdt_user_logic.restart(30);
        rd(off_stat, en | 32'h8);
        rd(off_irq, 32'h2);
        apb(1'b1, off_mask, 32'h3);
        irq_is(1'b1);
        apb(1'b1, off_irq, 32'h2);
        irq_is(1'b0);
        u_wdt_user_logic.edges(8);
        rd(off_stat, en);
        chk(n_reconf, 32'h0);
        u_wdt_user_logic.edges(1);
        chk(n_reconf, 32'h1);
        rd(off_mode, 32'h0);
        chk({30'h0, image_mode}, 32'h0);
        apb(1'b0, off_stat, 32'h0);
        chk({30'h0, r[30:29]}, 32'h2);
        rd(off_irq, 32'h1);
        irq_is(1'b1);
        apb(1'b1, off_stat, 32'h4000_0000);
        apb(1'b0, off_stat, 32'h0);
        chk({31'h0, r[30]}, 32'h0);
        apb(1'b1, off_irq, 32'h1);
        irq_is(1'b0);
        u_wdt_user_logic.edges(12);
        chk(n_reconf, 32'h1);
        // internal oscillator tick: expiry on the ninth tick of pclk/10
        apb(1'b1, off_ctrl, 32'h0);
        apb(1'b1, off_mode, 32'h1);
        repeat (40) @(posedge pclk);
        apb(1'b0, off_stat, 32'h0);
        chk({31'h0, r[29]}, 32'h1);
        repeat (100) @(posedge pclk);
        chk(n_reconf, 32'h2);
        close_out();
    end
endmodule : tb

// *** bench/wdt_checker_assertions.sv ***
// Purpose: port checks of the user watchdog
// Assumes: one pclk domain
// Notes: bound to the top module
`timescale 1ns/10ps
module wdt_checker
    import wdt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic reconfig_factory,
    input wire logic [wdt_pkg::mode_w-1:0] image_mode
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_READY_NEXT: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("pready held");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_RECONF_ONE: assert property (reconfig_factory |=> !reconfig_factory)
        else $error("reload pulse too long");
    AST_RECONF_MODE: assert property (reconfig_factory |-> ##[0:2] image_mode == mode_factory)
        else $error("no return to factory");
    AST_RECONF_USER: assert property (reconfig_factory |-> $past(image_mode) == mode_user)
        else $error("timeout outside user mode");
    AST_USER_LOAD: assert property ($rose(image_mode == mode_user) |-> $past(image_mode) == mode_loading)
        else $error("user mode without loading");
    AST_LEAVE_USER: assert property ((image_mode == mode_user) ##1 (image_mode != mode_user)
        |-> reconfig_factory || $past(reconfig_factory))
        else $error("user mode left without timeout");
    cover property (reconfig_factory);
    cover property (pslverr);
    cover property ($rose(image_mode == mode_user));
endmodule : wdt_checker
bind remote_upgrade_user_watchdog wdt_checker u_wdt_checker (.pclk, .presetn, .psel, .penable,
    .pready, .pslverr, .reconfig_factory, .image_mode);

// *** bench/wdt_user_logic.sv ***
// Purpose: application logic beside the watchdog
// Assumes: called just after a pclk edge
// Notes: user clock stands low between bursts
`timescale 1ns/10ps
module wdt_user_logic (
    input wire logic pclk,
    output logic user_supplied_clock_pin,
    output logic watchdog_restart_n,
    output logic app_load_done
);
    initial begin
        user_supplied_clock_pin = 1'b0;
        watchdog_restart_n = 1'b1;
        app_load_done = 1'b0;
    end
    // period of 8 pclk, below a quarter of pclk
    task edges(input int n);
        repeat (n) begin
            repeat (4) @(posedge pclk);
            user_supplied_clock_pin <= 1'b1;
            repeat (4) @(posedge pclk);
            user_supplied_clock_pin <= 1'b0;
        end
        repeat (8) @(posedge pclk);
    endtask : edges
    task restart(input int n);
        watchdog_restart_n <= 1'b0;
        repeat (n) @(posedge pclk);
        watchdog_restart_n <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask : restart
    task load();
        app_load_done <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask : load
endmodule : wdt_user_logic

// *** core/remote_upgrade_user_watchdog.sv ***
// Purpose: user watchdog of the remote upgrade logic, apb slave
// Assumes: pclk 100 MHz, pins asynchronous
// Notes: zero wait-state apb; one image mode machine
`timescale 1ns/10ps
module remote_upgrade_user_watchdog (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic user_supplied_clock_pin,
    input wire logic watchdog_restart_n,
    input wire logic app_load_done,
    output logic irq,
    output logic reconfig_factory,
    output logic [wdt_pkg::mode_w-1:0] image_mode
);
    import wdt_pkg::*;
    logic [set_w-1:0] setting;
    logic clk_sel, start_load;
    logic [cnt_w-1:0] cnt_q, cnt_d;
    img_mode_t mode_q, mode_d;
    logic [1:0] ld_q;
    logic rcf_q, rcf_d;
    logic tmo, en;
    logic [cnt_w-1:0] load_val;

    wdt_tick_if t ();

    wdt_tick_gen u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .clk_sel(clk_sel),
        .user_supplied_clock_pin(user_supplied_clock_pin),
        .watchdog_restart_n(watchdog_restart_n),
        .t(t)
    );

    wdt_apb u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .irq(irq),
        .setting(setting),
        .clk_sel(clk_sel),
        .start_load(start_load),
        .mode(mode_q),
        .count(cnt_q),
        .load_val(load_val),
        .en(en),
        .tmo(tmo),
        .restart_ev(t.restart)
    );

    // load done comes from the configuration engine, another domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ld_q <= 2'h0;
        end else begin
            ld_q <= {ld_q[0], app_load_done};
        end
    end

    assign load_val = {setting, low_fill};
    assign en = (mode_q == mode_user);

    // image mode and counter
    always_comb begin
        mode_d = mode_q;
        cnt_d = cnt_q;
        tmo = 1'b0;
        rcf_d = 1'b0;
        unique case (mode_q)
            mode_factory: begin
                cnt_d = load_val;
                // a new image may only be started from the factory image
                if (start_load) begin
                    mode_d = mode_loading;
                end
            end
            mode_loading: begin
                // counter held at its load value while the image comes in
                cnt_d = load_val;
                if (ld_q[1]) begin
                    mode_d = mode_user;
                end
            end
            mode_user: begin
                if (t.restart) begin
                    cnt_d = load_val;
                end else if (t.tick) begin
                    if (cnt_q == '0) begin
                        tmo = 1'b1;
                    end else begin
                        cnt_d = cnt_q - 1'b1;
                    end
                end
                if (tmo) begin
                    // back to the factory image, setting stays for next try
                    mode_d = mode_factory;
                    rcf_d = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= mode_factory;
            cnt_q <= '0;
            rcf_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            cnt_q <= cnt_d;
            rcf_q <= rcf_d;
        end
    end

    assign reconfig_factory = rcf_q;
    assign image_mode = mode_q;
endmodule : remote_upgrade_user_watchdog

// *** core/wdt_apb.sv ***
// Purpose: apb slave register file for the user watchdog
// Assumes: zero wait states
// Notes: unmapped offsets read zero and raise pslverr
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module wdt_apb (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic [wdt_pkg::set_w-1:0] setting,
    output logic clk_sel,
    output logic start_load,
    input wire logic [wdt_pkg::mode_w-1:0] mode,
    input wire logic [wdt_pkg::cnt_w-1:0] count,
    input wire logic [wdt_pkg::cnt_w-1:0] load_val,
    input wire logic en,
    input wire logic tmo,
    input wire logic restart_ev
);
    import wdt_pkg::*;
    logic [set_w-1:0] set_q, set_d;
    logic clksel_q, clksel_d;
    logic flag_q, flag_d;
    logic [irq_w-1:0] ist_q, ist_d;
    logic [irq_w-1:0] msk_q, msk_d;
    logic [irq_w-1:0] ev, w1c;
    logic [31:0] rd_d;
    logic [31:0] prdata_q;
    logic err_d, irq_d, rdy_d, go_d;
    logic pready_q, pslverr_q, irq_q;
    logic wr, acc, factory;

    always_comb begin
        wr = psel & penable & pwrite;
        acc = psel & ~penable;
        factory = (mode == mode_factory);
        set_d = set_q;
        clksel_d = clksel_q;
        msk_d = msk_q;
        flag_d = flag_q;
        go_d = 1'b0;
        ev = '0;
        ev[irq_timeout_bit] = tmo;
        ev[irq_restart_bit] = restart_ev & en;
        w1c = '0;
        rd_d = 32'h0000_0000;
        err_d = 1'b0;
        rdy_d = acc;
        if (tmo) begin
            flag_d = 1'b1;
        end
        if (acc) begin
            unique case (paddr)
                off_ctrl: rd_d = {19'h0, clksel_q, set_q};
                off_stat: rd_d = {1'b0, flag_q, en, count};
                off_irq: rd_d = {30'h0, ist_q};
                off_mask: rd_d = {30'h0, msk_q};
                off_count: rd_d = {3'h0, load_val};
                off_mode: rd_d = {30'h0, mode};
                default: err_d = 1'b1;
            endcase
        end
        if (wr) begin
            unique case (paddr)
                off_ctrl: begin
                    // only the factory image may change the setting
                    if (factory) begin
                        set_d = pwdata[ctrl_set_lsb +: set_w];
                        clksel_d = pwdata[ctrl_clksel_bit];
                    end
                end
                off_stat: begin
                    // a timeout in the same cycle keeps the flag
                    if (pwdata[30] && !tmo) begin
                        flag_d = 1'b0;
                    end
                end
                off_irq: w1c = pwdata[irq_w-1:0];
                off_mask: msk_d = pwdata[irq_w-1:0];
                off_mode: go_d = factory & pwdata[0];
                default: ;
            endcase
        end
        // set wins over clear
        ist_d = (ist_q & ~w1c) | ev;
        irq_d = |(ist_d & msk_d);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            set_q <= set_rst;
            clksel_q <= 1'b0;
            flag_q <= 1'b0;
            ist_q <= '0;
            msk_q <= '0;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            set_q <= set_d;
            clksel_q <= clksel_d;
            flag_q <= flag_d;
            ist_q <= ist_d;
            msk_q <= msk_d;
            prdata_q <= rd_d;
            pready_q <= rdy_d;
            pslverr_q <= err_d;
            irq_q <= irq_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
    assign setting = set_q;
    assign clk_sel = clksel_q;
    assign start_load = go_d;
endmodule : wdt_apb

// *** core/wdt_pkg.sv ***
// Purpose: constants and types for the user watchdog block
// Assumes: pclk at 100 MHz, apb with 32-bit data
// Notes: register offsets are byte addresses
package wdt_pkg;
    localparam int cnt_w = 29;
    localparam int set_w = 12;
    localparam int low_w = 17;
    localparam logic [low_w-1:0] low_fill = 17'b1000;
    localparam logic [7:0] off_ctrl = 8'h00;
    localparam logic [7:0] off_stat = 8'h04;
    localparam logic [7:0] off_irq = 8'h08;
    localparam logic [7:0] off_mask = 8'h0c;
    localparam logic [7:0] off_count = 8'h10;
    localparam logic [7:0] off_mode = 8'h14;
    localparam int ctrl_set_lsb = 0;
    localparam int ctrl_clksel_bit = 12;
    localparam int stat_en_bit = 29;
    localparam int mode_w = 2;
    localparam int irq_timeout_bit = 0;
    localparam int irq_restart_bit = 1;
    localparam int irq_w = 2;
    localparam logic [set_w-1:0] set_rst = 12'hfff;
    localparam int clk_mhz = 100;
    localparam int osc_khz = 10000;
    localparam int usr_max_khz = 40000;
    localparam int restart_min_ns = 250;
    // least time rounds up
    localparam int restart_min_cyc = (restart_min_ns * clk_mhz + 999) / 1000;
    localparam int osc_div = (clk_mhz * 1000) / osc_khz;
    typedef enum logic [1:0] {mode_factory, mode_loading, mode_user} img_mode_t;
endpackage : wdt_pkg

// *** core/wdt_tick_gen.sv ***
// Purpose: count tick source and restart qualifier
// Assumes: pins are asynchronous to pclk
// Notes: user clock pin is sampled, so it must stay below a quarter of pclk
`timescale 1ns/10ps
module wdt_tick_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_sel,
    input wire logic user_supplied_clock_pin,
    input wire logic watchdog_restart_n,
    wdt_tick_if.src t
);
    import wdt_pkg::*;
    logic [2:0] uck_q, uck_d;
    logic [1:0] rs_q, rs_d;
    logic [7:0] div_q, div_d;
    logic [7:0] low_q, low_d;
    logic tick_q, tick_d;
    logic rst_q, rst_d;
    always_comb begin
        uck_d = {uck_q[1:0], user_supplied_clock_pin};
        rs_d = {rs_q[0], watchdog_restart_n};
        div_d = (div_q == 8'(osc_div - 1)) ? 8'h00 : div_q + 8'h01;
        // osc tick from divider, user tick from rising edge
        tick_d = clk_sel ? (uck_q[1] & ~uck_q[2]) : (div_q == 8'(osc_div - 1));
        low_d = low_q;
        rst_d = 1'b0;
        if (rs_q[1]) begin
            low_d = 8'h00;
        end else if (low_q != 8'hff) begin
            low_d = low_q + 8'h01;
        end
        // one pulse once the strobe has been low long enough
        if (!rs_q[1] && low_q == 8'(restart_min_cyc - 1)) begin
            rst_d = 1'b1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uck_q <= 3'h0;
            rs_q <= 2'h3;
            div_q <= 8'h00;
            low_q <= 8'h00;
            tick_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            uck_q <= uck_d;
            rs_q <= rs_d;
            div_q <= div_d;
            low_q <= low_d;
            tick_q <= tick_d;
            rst_q <= rst_d;
        end
    end
    assign t.tick = tick_q;
    assign t.restart = rst_q;
endmodule : wdt_tick_gen

// *** core/wdt_tick_if.sv ***
// Purpose: carrier between watchdog core and its helpers
// Assumes: single pclk domain
// Notes: none
`timescale 1ns/10ps
interface wdt_tick_if;
    logic tick;
    logic restart;
    modport src (output tick, output restart);
    modport dst (input tick, input restart);
endinterface : wdt_tick_if
